// >>> hw/pcdc_pkg.sv
// Constants shared by the pin control and clock divider configuration block.
package pcdc_pkg;

   // Register addresses on the serial configuration port.
   localparam logic [14:0] ADDR_PD_OVERRIDE = 15'h003f;
   localparam logic [14:0] ADDR_PIN_FUNC    = 15'h0040;
   localparam logic [14:0] ADDR_DIV_RATIO   = 15'h0108;
   localparam logic [14:0] ADDR_DIV_PHASE   = 15'h0109;

   // Field positions.
   localparam int OVR_BIT      = 7;
   localparam int FUNC_MSB     = 7;
   localparam int FUNC_LSB     = 6;
   localparam int SEL_BD_MSB   = 5;
   localparam int SEL_BD_LSB   = 3;
   localparam int SEL_AC_MSB   = 2;
   localparam int SEL_AC_LSB   = 0;
   localparam int RATIO_MSB    = 2;
   localparam int PHASE_MSB    = 3;

   // Reset values.
   localparam logic       OVR_RESET      = 1'h0;
   localparam logic [7:0] PIN_FUNC_RESET = 8'h3f;
   localparam logic [2:0] RATIO_RESET    = 3'h1;
   localparam logic [3:0] PHASE_RESET    = 4'h0;

   // Power-down pin function codes.
   localparam logic [1:0] FUNC_POWER_DOWN = 2'h0;
   localparam logic [1:0] FUNC_STANDBY    = 2'h1;
   localparam logic [1:0] FUNC_IGNORE     = 2'h2;

   // Threshold flag pin source selections.
   localparam logic [2:0] SEL_FLAG     = 3'h0;
   localparam logic [2:0] SEL_LMFC     = 3'h1;
   localparam logic [2:0] SEL_SYNC     = 3'h2;
   localparam logic [2:0] SEL_DISABLED = 3'h7;

   // Divider ratio codes; the code plus one is the divide factor.
   localparam logic [2:0] RATIO_DIV1 = 3'h0;
   localparam logic [2:0] RATIO_DIV2 = 3'h1;
   localparam logic [2:0] RATIO_DIV4 = 3'h3;
   localparam logic [2:0] RATIO_DIV8 = 3'h7;

   // Serial port framing.
   localparam logic [4:0] INSTR_BITS = 5'h10;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int         READ_BIT   = 15;

   // Depth of the delay line, in half input clock cycles.
   localparam int PHASE_STEPS = 16;

   typedef enum logic [1:0] {
      SPI_IDLE  = 2'b00,
      SPI_INSTR = 2'b01,
      SPI_DATA  = 2'b10,
      SPI_DONE  = 2'b11
   } pcdc_spi_e;

endpackage : pcdc_pkg

// >>> hw/pcdc_clock_divider.sv
// Input clock divider with half-cycle phase offset, as one-cycle enables.
`timescale 1ns/1ps
module pcdc_clock_divider
   import pcdc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       run,
   input  wire logic [2:0] ratioCode,
   input  wire logic [3:0] phaseCode,
   output logic            inputClockTick,
   output logic            dividedTick
);

   typedef struct packed {
      logic                   inPhase;
      logic [2:0]             count;
      logic [PHASE_STEPS-1:0] line;
   } pcdc_div_s;

   pcdc_div_s st_reg;
   pcdc_div_s st_next;
   logic      divPulse;

   // The input clock is modelled at half the system rate, so one system
   // cycle is one half input cycle and every phase step is one flop.
   assign divPulse = st_reg.inPhase && (st_reg.count == ratioCode) && run;

   // Counter wraps at the ratio code; the four legal codes are all ones
   // below their top bit, so code plus one gives 1, 2, 4 or 8.
   always_comb begin
      st_next = st_reg;
      st_next.inPhase = ~st_reg.inPhase;
      if (!run) begin
         st_next.count = 3'h0;  // RULE11
      end else if (st_reg.inPhase) begin
         if (st_reg.count == ratioCode) begin
            st_next.count = 3'h0;  // RULE8
         end else begin
            st_next.count = st_reg.count + 3'h1;
         end
      end
      st_next.line = {st_reg.line[PHASE_STEPS-2:0], divPulse};
      if (!run) begin
         st_next.line = '0;
      end
      if (!resetn) begin
         st_next.inPhase = 1'b0;
         st_next.count   = 3'h0;
         st_next.line    = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   // Code 1 is the inverted input clock: one system cycle of shift.
   assign dividedTick    = st_reg.line[phaseCode];  // RULE9 RULE10 RULE12
   assign inputClockTick = st_reg.inPhase;

   // The phase code must also hold at the checked edge, because the tap
   // moves the moment a new code is written.
   a_div_by_two: assert property (@(posedge sys_clk) // RULE8
      disable iff (!resetn)
      (divPulse && ratioCode == RATIO_DIV2) ##1
      (ratioCode == RATIO_DIV2 && run) [*4] |-> divPulse)
      else $error("Divide by two period is not four half cycles.");

   a_phase_half: assert property (@(posedge sys_clk) // RULE10
      disable iff (!resetn)
      (divPulse && phaseCode == 4'h1) ##1 (phaseCode == 4'h1 && run)
      ##1 (phaseCode == 4'h1) |-> dividedTick)
      else $error("Half cycle phase offset not applied.");

   a_phase_seven: assert property (@(posedge sys_clk) // RULE9
      disable iff (!resetn)
      (divPulse && phaseCode == 4'h7) ##1 (phaseCode == 4'h7 && run) [*7]
      ##1 (phaseCode == 4'h7) |-> dividedTick)
      else $error("Phase code seven does not delay by seven halves.");

   a_phase_top: assert property (@(posedge sys_clk) // RULE12
      disable iff (!resetn)
      (divPulse && phaseCode == 4'hf) ##1 (phaseCode == 4'hf && run) [*8]
      ##1 (phaseCode == 4'hf && run) [*7] ##1 (phaseCode == 4'hf)
      |-> dividedTick)
      else $error("Phase code fifteen does not delay by fifteen halves.");

   a_halt_quiet: assert property (@(posedge sys_clk) // RULE11
      disable iff (!resetn)
      (!run) [*2] |-> !dividedTick)
      else $error("Divided clock runs while halted.");

endmodule : pcdc_clock_divider

// >>> hw/pcdc_pin_control.sv
// Pin control, threshold flag routing and clock divider configuration.
//
// Behaviour
// (RULE1) Override bit set ignores power-down pin and global pin selection.
// (RULE2) Function 00: asserted pin puts chip into full power-down.
// (RULE3) Function 01: asserted pin puts chip into standby instead.
// (RULE4) Function 10: pin assertion is ignored.
// (RULE5) B/D flag pin: 000 flag, 001 LMFC, 010 internal SYNC; reset 7.
// (RULE6) A/C flag pin: 000 flag, 001 LMFC, 010 internal SYNC; reset 7.
// (RULE7) Select 111 releases the flag pin as an input with pulldown.
// (RULE8) Divider ratio: 000 by 1, 001 by 2, 011 by 4, 111 by 8.
// (RULE9) Phase offset delays divider output by code half input cycles.
// (RULE10) Phase code 0001 gets its half cycle by inverting the clock.
// (RULE11) Full power-down stops data clocks, resets path, disables outputs.
// (RULE12) Phase codes 1000 to 1111 continue up to seven and a half.
// (RULE13) Host writes only listed ratio and pin function codes.
`timescale 1ns/1ps
module pcdc_pin_control
   import pcdc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic spiCsn,
   input  wire logic spiSclk,
   input  wire logic spiSdi,
   output logic      spiSdoOut,
   output logic      spiSdoOe,
   input  wire logic powerdownStandbyPin,
   input  wire logic fastDetectFlagAC,
   input  wire logic fastDetectFlagBD,
   input  wire logic jesdLmfc,
   input  wire logic jesdSyncInternal,
   output logic      thresholdFlagPinAOut,
   output logic      thresholdFlagPinAOe,
   output logic      thresholdFlagPinBOut,
   output logic      thresholdFlagPinBOe,
   output logic      fullPowerDown,
   output logic      standbyMode,
   output logic      dataPathReset,
   output logic      jesdEnable,
   output logic      outputsEnable,
   output logic      inputClockTick,
   output logic      dataPathClockTick
);

   typedef struct packed {
      logic [2:0] csSync;
      logic [2:0] sclkSync;
      logic [2:0] sdiSync;
      logic [2:0] pinSync;
      logic       csLevel;
      logic       sclkLevel;
      logic       pinLevel;
      pcdc_spi_e  spiState;
      logic [4:0] bitCount;
      logic [15:0] instr;
      logic [7:0] dataShift;
      logic       regOverride;
      logic [7:0] regPinFunc;
      logic [2:0] regDivRatio;
      logic [3:0] regDivPhase;
      logic       fullPowerDown;
      logic       standbyMode;
      logic       flagAOut;
      logic       flagAOe;
      logic       flagBOut;
      logic       flagBOe;
      logic       sdoOut;
      logic       sdoOe;
   } pcdc_top_s;

   pcdc_top_s st_reg;
   pcdc_top_s st_next;

   logic       sclkRise;
   logic       sclkFall;
   logic [1:0] pinFunc;
   logic [2:0] selAC;
   logic [2:0] selBD;
   logic [7:0] readData;
   logic       divTick;

   assign pinFunc = st_reg.regPinFunc[FUNC_MSB:FUNC_LSB];
   assign selAC   = st_reg.regPinFunc[SEL_AC_MSB:SEL_AC_LSB];
   assign selBD   = st_reg.regPinFunc[SEL_BD_MSB:SEL_BD_LSB];

   // Edges count only once the settled level moves, never on the first flop.
   assign sclkRise = !st_reg.sclkLevel && st_reg.sclkSync[1]
                     && st_reg.sclkSync[2];
   assign sclkFall = st_reg.sclkLevel && !st_reg.sclkSync[1]
                     && !st_reg.sclkSync[2];

   // Read mux; reserved bits and unmapped addresses read as zero.
   always_comb begin
      readData = 8'h00;
      if (st_reg.instr[14:0] == ADDR_PD_OVERRIDE) begin
         readData[OVR_BIT] = st_reg.regOverride;
      end else if (st_reg.instr[14:0] == ADDR_PIN_FUNC) begin
         readData = st_reg.regPinFunc;
      end else if (st_reg.instr[14:0] == ADDR_DIV_RATIO) begin
         readData[RATIO_MSB:0] = st_reg.regDivRatio;
      end else if (st_reg.instr[14:0] == ADDR_DIV_PHASE) begin
         readData[PHASE_MSB:0] = st_reg.regDivPhase;
      end
   end

   // Next state of the whole block; reset is applied here, synchronously.
   always_comb begin
      st_next = st_reg;
      st_next.csSync   = {st_reg.csSync[1:0], spiCsn};
      st_next.sclkSync = {st_reg.sclkSync[1:0], spiSclk};
      st_next.sdiSync  = {st_reg.sdiSync[1:0], spiSdi};
      st_next.pinSync  = {st_reg.pinSync[1:0], powerdownStandbyPin};
      if (st_reg.csSync[1] == st_reg.csSync[2]) begin
         st_next.csLevel = st_reg.csSync[2];
      end
      if (st_reg.sclkSync[1] == st_reg.sclkSync[2]) begin
         st_next.sclkLevel = st_reg.sclkSync[2];
      end
      if (st_reg.pinSync[1] == st_reg.pinSync[2]) begin
         st_next.pinLevel = st_reg.pinSync[2];
      end

      // Serial port: 16 instruction bits (read flag, address), 8 data bits.
      case (st_reg.spiState)
         SPI_IDLE: begin
            st_next.bitCount = 5'h00;
            st_next.sdoOe    = 1'b0;
            if (!st_reg.csLevel) begin
               st_next.spiState = SPI_INSTR;
            end
         end
         SPI_INSTR: begin
            if (sclkRise) begin
               st_next.instr    = {st_reg.instr[14:0], st_reg.sdiSync[2]};
               st_next.bitCount = st_reg.bitCount + 5'h01;
               if (st_reg.bitCount + 5'h01 == INSTR_BITS) begin
                  st_next.spiState = SPI_DATA;
               end
            end
         end
         SPI_DATA: begin
            // Read data is loaded once the instruction settles, then
            // advances on falling edges so the host samples on rising ones.
            if (st_reg.bitCount == INSTR_BITS && !sclkRise
                && st_reg.dataShift != readData
                && st_reg.instr[READ_BIT] && !st_reg.sdoOe) begin
               st_next.dataShift = readData;
               st_next.sdoOe     = 1'b1;
               st_next.sdoOut    = readData[7];
            end else if (sclkFall && st_reg.instr[READ_BIT]
                         && st_reg.bitCount != INSTR_BITS) begin
               st_next.sdoOut = st_reg.dataShift[7];
            end
            if (st_reg.bitCount == INSTR_BITS && st_reg.instr[READ_BIT]
                && !st_reg.sdoOe) begin
               st_next.dataShift = readData;
               st_next.sdoOe     = 1'b1;
               st_next.sdoOut    = readData[7];
            end
            if (sclkRise) begin
               st_next.bitCount = st_reg.bitCount + 5'h01;
               if (st_reg.instr[READ_BIT]) begin
                  st_next.dataShift = {st_reg.dataShift[6:0], 1'b0};
               end else begin
                  st_next.dataShift = {st_reg.dataShift[6:0],
                                       st_reg.sdiSync[2]};
               end
               if (st_reg.bitCount + 5'h01 == FRAME_BITS) begin
                  st_next.spiState = SPI_DONE;
               end
            end
         end
         default: begin
            // A write commits once, at the end of its frame.
            if (!st_reg.instr[READ_BIT] && st_reg.bitCount == FRAME_BITS) begin
               st_next.bitCount = 5'h00;
               if (st_reg.instr[14:0] == ADDR_PD_OVERRIDE) begin
                  st_next.regOverride = st_reg.dataShift[OVR_BIT];
               end else if (st_reg.instr[14:0] == ADDR_PIN_FUNC) begin
                  st_next.regPinFunc = st_reg.dataShift;
               end else if (st_reg.instr[14:0] == ADDR_DIV_RATIO) begin
                  st_next.regDivRatio = st_reg.dataShift[RATIO_MSB:0];
               end else if (st_reg.instr[14:0] == ADDR_DIV_PHASE) begin
                  st_next.regDivPhase = st_reg.dataShift[PHASE_MSB:0];
               end
            end
         end
      endcase
      if (st_reg.csLevel && st_reg.spiState != SPI_IDLE) begin
         st_next.spiState = SPI_IDLE;  // Chip select high aborts a frame.
         st_next.sdoOe    = 1'b0;
      end

      // Power-down pin handling; the override masks the pin completely.
      st_next.fullPowerDown = st_reg.pinLevel && !st_reg.regOverride
                              && pinFunc == FUNC_POWER_DOWN;  // RULE1 RULE2
      st_next.standbyMode   = st_reg.pinLevel && !st_reg.regOverride
                              && pinFunc == FUNC_STANDBY;  // RULE3 RULE4

      // Threshold flag pins; unlisted selects drive a quiet low.
      st_next.flagAOe  = selAC != SEL_DISABLED;  // RULE7
      st_next.flagBOe  = selBD != SEL_DISABLED;  // RULE7
      st_next.flagAOut = (selAC == SEL_FLAG && fastDetectFlagAC)
                         || (selAC == SEL_LMFC && jesdLmfc)
                         || (selAC == SEL_SYNC && jesdSyncInternal);  // RULE6
      st_next.flagBOut = (selBD == SEL_FLAG && fastDetectFlagBD)
                         || (selBD == SEL_LMFC && jesdLmfc)
                         || (selBD == SEL_SYNC && jesdSyncInternal);  // RULE5

      if (!resetn) begin
         st_next = '0;
         st_next.csSync      = 3'h7;
         st_next.csLevel     = 1'b1;
         st_next.spiState    = SPI_IDLE;
         st_next.regOverride = OVR_RESET;
         st_next.regPinFunc  = PIN_FUNC_RESET;  // RULE5 RULE6
         st_next.regDivRatio = RATIO_RESET;  // RULE8
         st_next.regDivPhase = PHASE_RESET;  // RULE9
      end
   end

   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   // The divider is held while powered down, stopping the data path clock.
   pcdc_clock_divider u_divider (
      .sys_clk        (sys_clk),
      .resetn         (resetn),
      .run            (!st_reg.fullPowerDown),
      .ratioCode      (st_reg.regDivRatio),
      .phaseCode      (st_reg.regDivPhase),
      .inputClockTick (inputClockTick),
      .dividedTick    (divTick)
   );

   // Outputs follow their flops; power-down gates the data path.
   assign dataPathClockTick    = divTick;
   assign fullPowerDown        = st_reg.fullPowerDown;
   assign standbyMode          = st_reg.standbyMode;
   assign dataPathReset        = st_reg.fullPowerDown;  // RULE11
   assign jesdEnable           = !st_reg.fullPowerDown;  // RULE11
   assign outputsEnable        = !st_reg.fullPowerDown;  // RULE11
   assign thresholdFlagPinAOut = st_reg.flagAOut;
   assign thresholdFlagPinAOe  = st_reg.flagAOe;
   assign thresholdFlagPinBOut = st_reg.flagBOut;
   assign thresholdFlagPinBOe  = st_reg.flagBOe;
   assign spiSdoOut            = st_reg.sdoOut;
   assign spiSdoOe             = st_reg.sdoOe;

   a_override_mask: assert property (@(posedge sys_clk) // RULE1
      disable iff (!resetn)
      st_reg.regOverride |=> !st_reg.fullPowerDown && !st_reg.standbyMode)
      else $error("Power-down pin acted while overridden.");

   a_full_powerdown: assert property (@(posedge sys_clk) // RULE2
      disable iff (!resetn)
      (st_reg.pinLevel && !st_reg.regOverride && pinFunc == FUNC_POWER_DOWN)
      |=> st_reg.fullPowerDown && !st_reg.standbyMode)
      else $error("Pin did not cause full power-down.");

   a_standby_entry: assert property (@(posedge sys_clk) // RULE3
      disable iff (!resetn)
      (st_reg.pinLevel && !st_reg.regOverride && pinFunc == FUNC_STANDBY)
      |=> st_reg.standbyMode && !st_reg.fullPowerDown)
      else $error("Pin did not cause standby.");

   a_pin_ignored: assert property (@(posedge sys_clk) // RULE4
      disable iff (!resetn)
      (pinFunc == FUNC_IGNORE)
      |=> !st_reg.fullPowerDown && !st_reg.standbyMode)
      else $error("Ignored pin changed power state.");

   a_flag_b_lmfc: assert property (@(posedge sys_clk) // RULE5
      disable iff (!resetn)
      (selBD == SEL_LMFC)
      |=> thresholdFlagPinBOut == $past(jesdLmfc) && thresholdFlagPinBOe)
      else $error("B/D flag pin does not carry LMFC.");

   a_flag_a_sync: assert property (@(posedge sys_clk) // RULE6
      disable iff (!resetn)
      (selAC == SEL_SYNC)
      |=> thresholdFlagPinAOut == $past(jesdSyncInternal)
      && thresholdFlagPinAOe)
      else $error("A/C flag pin does not carry internal SYNC.");

   a_flag_release: assert property (@(posedge sys_clk) // RULE7
      disable iff (!resetn)
      (selAC == SEL_DISABLED) |=> !thresholdFlagPinAOe)
      else $error("Disabled A/C flag pin still driven.");

   a_flag_b_release: assert property (@(posedge sys_clk) // RULE7
      disable iff (!resetn)
      (selBD == SEL_DISABLED) |=> !thresholdFlagPinBOe)
      else $error("Disabled B/D flag pin still driven.");

   a_pd_no_clock: assert property (@(posedge sys_clk) // RULE11
      disable iff (!resetn)
      st_reg.fullPowerDown [*3] |-> !dataPathClockTick && !jesdEnable)
      else $error("Data path clock runs in full power-down.");

endmodule : pcdc_pin_control

// >>> dv/pcdc_spi_host.sv
// Host model that runs framed accesses on the serial configuration port.
`timescale 1ns/1ps
module pcdc_spi_host (
   input  wire logic sys_clk,
   output logic      spiCsn,
   output logic      spiSclk,
   output logic      spiSdi,
   input  wire logic spiSdoOut,
   input  wire logic spiSdoOe
);
   // Each sclk phase spans 6 cycles, above the 4-cycle minimum for margin.
   localparam int HALF = 6;

   // Select high and serial clock parked low between frames.
   initial begin
      spiCsn  = 1'b1;
      spiSclk = 1'b0;
      spiSdi  = 1'b0;
   end

   task automatic waitn(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : waitn

   // One 24-bit frame, MSB first; read bits are taken as sclk rises.
   task automatic frame(input logic rd, input logic [14:0] addr,
                        input logic [7:0] wd, output logic [7:0] rdat,
                        output logic oeOk);
      logic [23:0] sh;
      sh     = {rd, addr, wd};
      rdat   = 8'h00;
      oeOk   = 1'b1;
      spiCsn = 1'b0;
      waitn(HALF);
      for (int i = 23; i >= 0; i--) begin
         spiSdi = sh[i];
         waitn(HALF);
         spiSclk = 1'b1;
         if (i < 8) begin
            rdat[i] = spiSdoOut;
            oeOk    = oeOk & spiSdoOe;
         end
         waitn(HALF);
         spiSclk = 1'b0;
      end
      // Released data line shows the inverse so a stale bit is never trusted.
      spiSdi = ~spiSdi;
      waitn(HALF);
      spiCsn = 1'b1;
      waitn(HALF);
   endtask : frame
endmodule : pcdc_spi_host

// >>> dv/pcdc_pin_control_tb.sv
// Self-checking bench for the pin control and clock divider registers.
`timescale 1ns/1ps
module pcdc_pin_control_tb;
   import pcdc_pkg::*;
   logic        sys_clk;
   logic        resetn;
   logic        pdPin;
   logic        flagAC;
   logic        flagBD;
   logic        lmfc;
   logic        syncInt;
   logic [31:0] rng;
   int          nFail;
   int          nChecks;
   int          cyc;
   wire         csn, sclk, sdi, sdo, sdoOe, aOut, aOe, bOut, bOe;
   wire         fpd, stby, dpr, jesdEn, outEn, dpTick, ictk;

   pcdc_spi_host i_pcdc_spi_host (
      .sys_clk(sys_clk), .spiCsn(csn), .spiSclk(sclk), .spiSdi(sdi),
      .spiSdoOut(sdo), .spiSdoOe(sdoOe)
   );

   pcdc_pin_control i_pcdc_pin_control (
      .sys_clk(sys_clk), .resetn(resetn), .spiCsn(csn), .spiSclk(sclk),
      .spiSdi(sdi), .spiSdoOut(sdo), .spiSdoOe(sdoOe),
      .powerdownStandbyPin(pdPin), .fastDetectFlagAC(flagAC),
      .fastDetectFlagBD(flagBD), .jesdLmfc(lmfc),
      .jesdSyncInternal(syncInt), .thresholdFlagPinAOut(aOut),
      .thresholdFlagPinAOe(aOe), .thresholdFlagPinBOut(bOut),
      .thresholdFlagPinBOe(bOe), .fullPowerDown(fpd), .standbyMode(stby),
      .dataPathReset(dpr), .jesdEnable(jesdEn), .outputsEnable(outEn),
      .inputClockTick(ictk), .dataPathClockTick(dpTick)
   );

   // Free-running 125 MHz system clock.
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Cycle count gives the time base for divider period and phase.
   always @(posedge sys_clk) cyc <= cyc + 1;

   function automatic logic [31:0] nextRand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : nextRand

   // Expected {enable, level} of a flag pin; a released pin is not driven.
   function automatic logic [1:0] expPin(input logic [2:0] s, input logic f);
      case (s)
         SEL_FLAG: return {1'b1, f};
         SEL_LMFC: return {1'b1, lmfc};
         SEL_SYNC: return {1'b1, syncInt};
         default:  return 2'b00;
      endcase
   endfunction : expPin

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrapUp

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      nChecks++;
      if (got !== exp) begin
         nFail++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chkPin(input logic [1:0] got, input logic [1:0] exp,
                         input string what);
      nChecks++;
      if (got !== exp) begin
         nFail++;
         $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chkPin

   task automatic waitCyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : waitCyc

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic       ok;
      i_pcdc_spi_host.frame(1'b0, a, d, r, ok);
   endtask : wr

   // Read data must be driven in every data bit and released after select.
   task automatic rdChk(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] r;
      logic       ok;
      i_pcdc_spi_host.frame(1'b1, a, 8'h00, r, ok);
      chk(r, e, "register read");
      chkPin({ok, sdoOe}, 2'b10, "read drive");
   endtask : rdChk

   // Bounded wait for one divider pulse; a missing pulse ends the run.
   task automatic tickAt(output int t);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (dpTick !== 1'b1 && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
      t = cyc;
      if (n >= 60) begin
         nFail++;
         $display("BAD %0t no divider pulse", $time);
         wrapUp();
      end
   endtask : tickAt

   task automatic doReset();
      resetn = 1'b0;
      waitCyc(5);
      resetn = 1'b1;
      waitCyc(3);
   endtask : doReset

   task automatic resetVals();
      rdChk(ADDR_PD_OVERRIDE, 8'h00);
      rdChk(ADDR_PIN_FUNC, 8'h3f);
      rdChk(ADDR_DIV_RATIO, 8'h01);
      rdChk(ADDR_DIV_PHASE, 8'h00);
      chkPin({aOe, bOe}, 2'b00, "flag enables");
   endtask : resetVals

   // Main sequence: registers, divider, power pin, then flag routing.
   initial begin
      int         t0, t1, n;
      logic       e;
      logic [2:0] selA, selB;
      logic [2:0] codes [4];
      logic [2:0] sels [4];
      codes   = '{3'h0, 3'h1, 3'h3, 3'h7};
      sels    = '{3'h0, 3'h1, 3'h2, 3'h7};
      rng     = 32'h1243;
      resetn  = 1'b0;
      pdPin   = 1'b0;
      flagAC  = 1'b0;
      flagBD  = 1'b0;
      lmfc    = 1'b0;
      syncInt = 1'b0;
      doReset();
      resetVals();
      wr(15'h0041, 8'hff);
      rdChk(15'h0041, 8'h00);
      wr(ADDR_PD_OVERRIDE, 8'hff);
      wr(ADDR_PIN_FUNC, 8'hbf);
      wr(ADDR_DIV_RATIO, 8'hff);
      wr(ADDR_DIV_PHASE, 8'hff);
      rdChk(ADDR_PD_OVERRIDE, 8'h80);
      rdChk(ADDR_PIN_FUNC, 8'hbf);
      rdChk(ADDR_DIV_RATIO, 8'h07);
      rdChk(ADDR_DIV_PHASE, 8'h0f);
      doReset();
      resetVals();
      $display("test registers done");
      // The modelled input clock must flip on every system cycle.
      e = ictk;
      waitCyc(1);
      chkPin({1'b0, e ^ ictk}, 2'b01, "input clock");
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_DIV_RATIO, {5'h00, codes[k]});
         waitCyc(40);
         tickAt(t0);
         tickAt(t1);
         chk(8'(t1 - t0), 8'(2 << k), "period");
      end
      tickAt(t0);
      for (int p = 0; p < 16; p++) begin
         wr(ADDR_DIV_PHASE, {4'h0, 4'(p)});
         waitCyc(40);
         tickAt(t1);
         chk(8'((t1 - t0) % 16), 8'(p), "phase");
      end
      $display("test divider done");
      for (int f = 0; f < 3; f++) begin
         for (int o = 0; o < 2; o++) begin
            for (int p = 0; p < 2; p++) begin
               wr(ADDR_PIN_FUNC, {2'(f), 6'h3f});
               wr(ADDR_PD_OVERRIDE, {1'(o), 7'h00});
               pdPin = 1'(p);
               waitCyc(8);
               e = (p == 1) && (o == 0) && (f == 0);
               n = 0;
               repeat (30) begin
                  @(negedge sys_clk);
                  n += int'(dpTick === 1'b1);
               end
               chkPin({fpd, stby}, {e, p == 1 && o == 0 && f == 1},
                      "power mode");
               chkPin({jesdEn, outEn}, {!e, !e}, "enables");
               chkPin({dpr, n == 0}, {e, e}, "path hold");
            end
         end
      end
      pdPin = 1'b0;
      $display("test power pin done");
      for (int k = 0; k < 4; k++) begin
         selB = sels[k];
         selA = sels[3 - k];
         wr(ADDR_PIN_FUNC, {2'h2, selB, selA});
         repeat (8) begin
            void'(nextRand());
            {flagAC, flagBD, lmfc, syncInt} = rng[3:0];
            waitCyc(2);
            chkPin({aOe, aOut & aOe}, expPin(selA, flagAC),
                   "pin a");
            chkPin({bOe, bOut & bOe}, expPin(selB, flagBD),
                   "pin b");
         end
      end
      $display("test flag routing done");
      wrapUp();
   end
endmodule : pcdc_pin_control_tb
